// ==== acc_corr_path.sv ====
// gain and offset correction stage for one conversion result
`timescale 1ns/1ps
`default_nettype none

module acc_corr_path
(
    // clock and reset
    input  wire logic                  ref_clk,
    input  wire logic                  reset,
    // raw sample and trim settings
    input  wire acc_pkg::acc_sample_t  sample,
    input  wire acc_pkg::acc_corr_cfg_t cfg,
    // corrected result
    output acc_pkg::acc_result_t       result
);

    logic signed [13:0] diff;
    logic signed [26:0] prod;
    logic signed [15:0] scaled;
    logic        [11:0] corrected;

    // ------------------------------------------------------------
    // (raw - signed offset) * unsigned 1.11 gain, saturated
    // ------------------------------------------------------------
    always_comb
    begin
        diff   = $signed({2'b00, sample.data})
               - $signed({{2{cfg.offset[11]}}, cfg.offset});
        prod   = diff * $signed({1'b0, cfg.gain});
        scaled = prod[acc_pkg::GAIN_FRAC + 15 : acc_pkg::GAIN_FRAC];
        if (scaled < 0)
            corrected = 12'h000;
        else if (scaled > $signed({4'h0, acc_pkg::RESULT_MAX}))
            corrected = acc_pkg::RESULT_MAX;
        else
            corrected = scaled[11:0];
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
        begin
            result <= '0;
        end
        else
        begin
            result.valid <= sample.valid;
            if (sample.valid)
            begin
                if (cfg.enable)
                    result.data <= {4'h0, corrected};
                else
                    result.data <= {4'h0, sample.data};
            end
        end
    end

endmodule

`default_nettype wire

// ==== acc_pkg.sv ====
// constants and carrier types for the converter correction and calibration registers
package acc_pkg;

    // ------------------------------------------------------------
    // register indices (byte address is four times the index)
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_WIN_UPPER   = 10'h020;
    localparam logic [9:0] IDX_GAIN_TRIM   = 10'h024;
    localparam logic [9:0] IDX_OFFSET_TRIM = 10'h026;
    localparam logic [9:0] IDX_FACTORY     = 10'h028;
    localparam logic [9:0] IDX_DEBUG       = 10'h02A;
    localparam logic [9:0] IDX_CORR_CTRL   = 10'h02C;
    localparam logic [9:0] IDX_IRQ_STATUS  = 10'h02D;
    localparam logic [9:0] IDX_IRQ_MASK    = 10'h02E;

    // ------------------------------------------------------------
    // field layouts: writable masks
    // ------------------------------------------------------------
    localparam logic [15:0] MASK_WIN_UPPER   = 16'hFFFF;
    localparam logic [15:0] MASK_GAIN_TRIM   = 16'h0FFF;
    localparam logic [15:0] MASK_OFFSET_TRIM = 16'h0FFF;
    localparam logic [15:0] MASK_FACTORY     = 16'h07FF;
    localparam logic [15:0] MASK_DEBUG       = 16'h0001;
    localparam logic [15:0] MASK_CORR_CTRL   = 16'h0001;
    localparam logic [15:0] MASK_IRQ         = 16'h0003;

    localparam int BIAS_LSB      = 8;
    localparam int BIAS_MSB      = 10;
    localparam int LINEARITY_MSB = 7;
    localparam int RUN_HALT_BIT  = 0;
    localparam int CORR_ON_BIT   = 0;
    localparam int IRQ_RESULT    = 0;
    localparam int IRQ_WINDOW    = 1;

    // ------------------------------------------------------------
    // reset values and datapath constants
    // ------------------------------------------------------------
    localparam logic [15:0] RESET_WORD   = 16'h0000;
    localparam int          GAIN_FRAC    = 11;
    localparam logic [11:0] RESULT_MAX   = 12'hFFF;

    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic        valid;
        logic [11:0] data;
    } acc_sample_t;

    typedef struct packed {
        logic        enable;
        logic [11:0] gain;
        logic [11:0] offset;
    } acc_corr_cfg_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] data;
    } acc_result_t;

endpackage

// ==== acc_regs.sv ====
// correction, calibration and debug register block with window monitor and interrupt
//
// Behaviour
// - upper bound register limits window comparison
// - correction on applies gain trim
// - gain is unsigned 1.11, zero to just under two
// - correction on subtracts offset trim
// - offset trim is two's complement
// - unused trim bits read zero, read-only
// - debug mode halts converter unless run bit
// - run bit changes only while converter disabled
// - window hit flag set one cycle later
//
// Register access over APB was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module acc_regs
(
    // clock and reset
    input  wire logic                 ref_clk,
    input  wire logic                 reset,
    // apb slave
    input  wire logic                 psel,
    input  wire logic                 penable,
    input  wire logic                 pwrite,
    input  wire logic [11:0]          paddr,
    input  wire logic [31:0]          pwdata,
    input  wire logic [3:0]           pstrb,
    output logic      [31:0]          prdata,
    output logic                      pready,
    output logic                      pslverr,
    // converter side
    input  wire acc_pkg::acc_sample_t sample_in,
    input  wire logic                 conv_enabled,
    input  wire logic                 debug_mode,
    input  wire logic                 window_enable,
    output acc_pkg::acc_result_t      result,
    output logic                      conv_halt,
    output logic      [2:0]           bias_trim,
    output logic      [7:0]           linearity_trim,
    output logic                      window_hit_flag,
    // interrupt
    output logic                      irq
);

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [15:0] window_upper_bound_q;
    logic [15:0] gain_trim_q;
    logic [15:0] offset_trim_q;
    logic [15:0] factory_trim_word_q;
    logic [15:0] debug_behaviour_q;
    logic [15:0] corr_ctrl_q;
    logic [15:0] irq_status_q;
    logic [15:0] irq_mask_q;

    logic        access;
    logic        wr_en;
    logic        rd_en;
    logic [9:0]  reg_idx;
    logic        addr_ok;
    logic [15:0] rd_word;
    logic [15:0] status_d;
    logic [1:0]  events;
    logic        window_match;
    logic        wr_ok;
    acc_pkg::acc_sample_t sample_gated;
    acc_pkg::acc_corr_cfg_t corr_cfg;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    function automatic logic [15:0] merge16(input logic [15:0] old_v,
                                            input logic [31:0] wdata,
                                            input logic [3:0]  strb,
                                            input logic [15:0] mask);
        logic [15:0] v;
        v = old_v;
        if (strb[0])
            v[7:0] = wdata[7:0];
        if (strb[1])
            v[15:8] = wdata[15:8];
        return v & mask;
    endfunction

    function automatic logic hit(input logic [9:0] idx, input logic [9:0] want);
        return idx == want;
    endfunction

    // ------------------------------------------------------------
    // apb decode: one wait state, answer on second access cycle
    // ------------------------------------------------------------
    assign access  = psel & penable;
    assign wr_en   = access & pready & pwrite;
    assign rd_en   = access & ~pready & ~pwrite;
    assign reg_idx = paddr[11:2];

    always_comb
    begin
        addr_ok = 1'b1;
        rd_word = 16'h0000;
        if (paddr[1:0] != 2'b00)
            addr_ok = 1'b0;
        else if (hit(reg_idx, acc_pkg::IDX_WIN_UPPER))
            rd_word = window_upper_bound_q;
        else if (hit(reg_idx, acc_pkg::IDX_GAIN_TRIM))
            rd_word = gain_trim_q & acc_pkg::MASK_GAIN_TRIM;
        else if (hit(reg_idx, acc_pkg::IDX_OFFSET_TRIM))
            rd_word = offset_trim_q & acc_pkg::MASK_OFFSET_TRIM;
        else if (hit(reg_idx, acc_pkg::IDX_FACTORY))
            rd_word = factory_trim_word_q & acc_pkg::MASK_FACTORY;
        else if (hit(reg_idx, acc_pkg::IDX_DEBUG))
            rd_word = debug_behaviour_q;
        else if (hit(reg_idx, acc_pkg::IDX_CORR_CTRL))
            rd_word = corr_ctrl_q;
        else if (hit(reg_idx, acc_pkg::IDX_IRQ_STATUS))
            rd_word = irq_status_q;
        else if (hit(reg_idx, acc_pkg::IDX_IRQ_MASK))
            rd_word = irq_mask_q;
        else
            addr_ok = 1'b0;
    end

    // ------------------------------------------------------------
    // apb response registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            pready <= 1'b0;
        else
            pready <= access & ~pready;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            pslverr <= 1'b0;
        else
            pslverr <= access & ~pready & ~addr_ok;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            prdata <= 32'h0000_0000;
        else if (rd_en)
            prdata <= {16'h0000, rd_word};
        else if (pready)
            prdata <= 32'h0000_0000;
    end

    // ------------------------------------------------------------
    // trim, threshold, control and mask registers, one process per register
    // ------------------------------------------------------------
    assign wr_ok = wr_en & addr_ok;

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            window_upper_bound_q <= acc_pkg::RESET_WORD;
        else if (wr_ok && hit(reg_idx, acc_pkg::IDX_WIN_UPPER))
            window_upper_bound_q <= merge16(window_upper_bound_q, pwdata, pstrb,
                                            acc_pkg::MASK_WIN_UPPER);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            gain_trim_q <= acc_pkg::RESET_WORD;
        else if (wr_ok && hit(reg_idx, acc_pkg::IDX_GAIN_TRIM))
            gain_trim_q <= merge16(gain_trim_q, pwdata, pstrb,
                                   acc_pkg::MASK_GAIN_TRIM);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            offset_trim_q <= acc_pkg::RESET_WORD;
        else if (wr_ok && hit(reg_idx, acc_pkg::IDX_OFFSET_TRIM))
            offset_trim_q <= merge16(offset_trim_q, pwdata, pstrb,
                                     acc_pkg::MASK_OFFSET_TRIM);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            factory_trim_word_q <= acc_pkg::RESET_WORD;
        else if (wr_ok && hit(reg_idx, acc_pkg::IDX_FACTORY))
            factory_trim_word_q <= merge16(factory_trim_word_q, pwdata, pstrb,
                                           acc_pkg::MASK_FACTORY);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            corr_ctrl_q <= acc_pkg::RESET_WORD;
        else if (wr_ok && hit(reg_idx, acc_pkg::IDX_CORR_CTRL))
            corr_ctrl_q <= merge16(corr_ctrl_q, pwdata, pstrb,
                                   acc_pkg::MASK_CORR_CTRL);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            irq_mask_q <= acc_pkg::RESET_WORD;
        else if (wr_ok && hit(reg_idx, acc_pkg::IDX_IRQ_MASK))
            irq_mask_q <= merge16(irq_mask_q, pwdata, pstrb, acc_pkg::MASK_IRQ);
    end

    assign bias_trim      = factory_trim_word_q[acc_pkg::BIAS_MSB:acc_pkg::BIAS_LSB];
    assign linearity_trim = factory_trim_word_q[acc_pkg::LINEARITY_MSB:0];

    // ------------------------------------------------------------
    // debug behaviour: run bit locked while converter enabled
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (reset)
            debug_behaviour_q <= acc_pkg::RESET_WORD;
        else if (wr_en && hit(reg_idx, acc_pkg::IDX_DEBUG) && !conv_enabled
                 && paddr[1:0] == 2'b00)
            debug_behaviour_q <= merge16(debug_behaviour_q, pwdata, pstrb,
                                         acc_pkg::MASK_DEBUG);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            conv_halt <= 1'b0;
        else
            conv_halt <= debug_mode & ~debug_behaviour_q[acc_pkg::RUN_HALT_BIT];
    end

    // ------------------------------------------------------------
    // correction datapath; samples dropped while halted
    // ------------------------------------------------------------
    always_comb
    begin
        sample_gated       = sample_in;
        sample_gated.valid = sample_in.valid & ~conv_halt;
    end

    always_comb
    begin
        corr_cfg.enable = corr_ctrl_q[acc_pkg::CORR_ON_BIT];
        corr_cfg.gain   = gain_trim_q[11:0];
        corr_cfg.offset = offset_trim_q[11:0];
    end

    acc_corr_path u_corr
    (
        .ref_clk (ref_clk),
        .reset   (reset),
        .sample  (sample_gated),
        .cfg     (corr_cfg),
        .result  (result)
    );

    // ------------------------------------------------------------
    // window monitor: corrected result above upper bound
    // ------------------------------------------------------------
    assign window_match = window_enable & result.valid
                        & (result.data > window_upper_bound_q);

    // ------------------------------------------------------------
    // interrupt status: sticky, write one to clear, set wins
    // ------------------------------------------------------------
    assign events = {window_match, result.valid};

    always_comb
    begin
        status_d = irq_status_q;
        if (wr_en && addr_ok && hit(reg_idx, acc_pkg::IDX_IRQ_STATUS) && pstrb[0])
            status_d = status_d & ~pwdata[15:0];
        status_d = (status_d | {14'h0000, events}) & acc_pkg::MASK_IRQ;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            irq_status_q <= acc_pkg::RESET_WORD;
        else
            irq_status_q <= status_d;
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            irq <= 1'b0;
        else
            irq <= |(status_d & irq_mask_q);
    end

    always_ff @(posedge ref_clk)
    begin
        if (reset)
            window_hit_flag <= 1'b0;
        else
            window_hit_flag <= status_d[acc_pkg::IRQ_WINDOW];
    end

endmodule

`default_nettype wire

// ==== acc_regs_chk.sv ====
// assertion checker for the correction and calibration register block
`timescale 1ns/1ps
`default_nettype none

module acc_regs_chk
(
    // clock and reset
    input wire logic                 ref_clk,
    input wire logic                 reset,
    // apb slave
    input wire logic                 psel,
    input wire logic                 penable,
    input wire logic                 pwrite,
    input wire logic [11:0]          paddr,
    input wire logic [31:0]          pwdata,
    input wire logic [3:0]           pstrb,
    input wire logic [31:0]          prdata,
    input wire logic                 pready,
    input wire logic                 pslverr,
    // converter side
    input wire acc_pkg::acc_sample_t sample_in,
    input wire logic                 conv_enabled,
    input wire logic                 debug_mode,
    input wire logic                 window_enable,
    input wire acc_pkg::acc_result_t result,
    input wire logic                 conv_halt,
    input wire logic [2:0]           bias_trim,
    input wire logic [7:0]           linearity_trim,
    input wire logic                 window_hit_flag,
    // interrupt
    input wire logic                 irq
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    a_apb_one_wait: assert property (psel && penable && !pready |=> pready)
        else $error("pready missing after access cycle");
    a_ready_single: assert property (pready |=> !pready)
        else $error("pready held longer than one cycle");
    a_ready_cause: assert property (pready |-> $past(psel && penable))
        else $error("pready without access phase");
    a_rdata_upper_zero: assert property (pready |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    a_err_no_data: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
        else $error("error response carries data");
    a_result_timing: assert property (sample_in.valid && !conv_halt |=> result.valid)
        else $error("accepted sample gave no result");
    a_halted_drop: assert property (!(sample_in.valid && !conv_halt) |=> !result.valid)
        else $error("result without accepted sample");
    a_result_clamp: assert property (result.valid |-> result.data[15:12] == 4'h0)
        else $error("result outside twelve bit range");
    a_halt_debug: assert property (!debug_mode |=> !conv_halt)
        else $error("halt outside debug mode");
    a_hit_after_result: assert property ($rose(window_hit_flag) |-> $past(result.valid))
        else $error("window flag without result");
    a_hit_needs_enable: assert property ($rose(window_hit_flag) |-> $past(window_enable))
        else $error("window flag with monitor off");
    a_trim_by_write: assert property ($changed(bias_trim) |-> $past(pready && pwrite))
        else $error("bias trim changed without write");
endmodule

bind acc_regs acc_regs_chk u_chk
(
    .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_in(sample_in), .conv_enabled(conv_enabled),
    .debug_mode(debug_mode), .window_enable(window_enable), .result(result),
    .conv_halt(conv_halt), .bias_trim(bias_trim), .linearity_trim(linearity_trim),
    .window_hit_flag(window_hit_flag), .irq(irq)
);

`default_nettype wire

// ==== acc_regs_tb.sv ====
// self-checking testbench for the correction and calibration register block
`timescale 1ns/1ps
`default_nettype none

module acc_regs_tb;
    logic                ref_clk, reset, psel, penable, pwrite, pready, pslverr;
    logic [11:0]         paddr;
    logic [31:0]         pwdata, prdata;
    logic [3:0]          pstrb;
    acc_pkg::acc_sample_t sample_in;
    acc_pkg::acc_result_t result;
    logic                conv_enabled, debug_mode, window_enable, conv_halt;
    logic [2:0]          bias_trim;
    logic [7:0]          linearity_trim;
    logic                window_hit_flag, irq;
    int                  errors, check_count, cycles;

    acc_regs DUT
    (
        .ref_clk(ref_clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .sample_in(sample_in), .conv_enabled(conv_enabled),
        .debug_mode(debug_mode), .window_enable(window_enable), .result(result),
        .conv_halt(conv_halt), .bias_trim(bias_trim), .linearity_trim(linearity_trim),
        .window_hit_flag(window_hit_flag), .irq(irq)
    );

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge ref_clk);
        penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge ref_clk);
    endtask

    task automatic wr(input logic [9:0] idx, input logic [15:0] d);
        logic [31:0] r;
        logic        e;
        apb(1'b1, idx, {16'h0000, d}, r, e);
    endtask

    task automatic rd(input logic [9:0] idx, input logic [31:0] exp);
        logic [31:0] r;
        logic        e;
        apb(1'b0, idx, 32'h0, r, e);
        chk(r, exp);
    endtask

    task automatic conv(input logic [11:0] raw, input logic vld, input logic [15:0] exp);
        sample_in <= '{valid: 1'b1, data: raw};
        @(posedge ref_clk);
        sample_in.valid <= 1'b0;
        @(posedge ref_clk);
        chk({31'h0, result.valid}, {31'h0, vld});
        if (vld)
            chk({16'h0, result.data}, {16'h0, exp});
    endtask

    task automatic end_of_test;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs;
        logic [31:0] r;
        logic        e;
        rd(acc_pkg::IDX_GAIN_TRIM, 32'h0);
        rd(acc_pkg::IDX_FACTORY, 32'h0);
        wr(acc_pkg::IDX_WIN_UPPER, 16'hFFFF);
        rd(acc_pkg::IDX_WIN_UPPER, 32'h0000_FFFF);
        wr(acc_pkg::IDX_GAIN_TRIM, 16'h0FFF);
        rd(acc_pkg::IDX_GAIN_TRIM, 32'h0000_0FFF);
        wr(acc_pkg::IDX_OFFSET_TRIM, 16'h0FFF);
        rd(acc_pkg::IDX_OFFSET_TRIM, 32'h0000_0FFF);
        wr(acc_pkg::IDX_FACTORY, 16'h07FF);
        rd(acc_pkg::IDX_FACTORY, 32'h0000_07FF);
        wr(acc_pkg::IDX_FACTORY, 16'h0512);
        chk({29'h0, bias_trim}, 32'h5);
        chk({24'h0, linearity_trim}, 32'h12);
        apb(1'b0, 10'h3FF, 32'h0, r, e);
        chk({31'h0, e}, 32'h1);
        chk(r, 32'h0);
    endtask

    task automatic t_debug;
        conv_enabled <= 1'b1;
        wr(acc_pkg::IDX_DEBUG, 16'h0001);
        rd(acc_pkg::IDX_DEBUG, 32'h0);
        debug_mode <= 1'b1;
        repeat (2) @(posedge ref_clk);
        chk({31'h0, conv_halt}, 32'h1);
        conv(12'h123, 1'b0, 16'h0);
        conv_enabled <= 1'b0;
        wr(acc_pkg::IDX_DEBUG, 16'h0001);
        rd(acc_pkg::IDX_DEBUG, 32'h1);
        chk({31'h0, conv_halt}, 32'h0);
        conv(12'h123, 1'b1, 16'h0123);
        debug_mode <= 1'b0;
    endtask

    task automatic t_corr;
        wr(acc_pkg::IDX_CORR_CTRL, 16'h0001);
        wr(acc_pkg::IDX_GAIN_TRIM, 16'h0800);
        wr(acc_pkg::IDX_OFFSET_TRIM, 16'h0FFE);
        conv(12'd100, 1'b1, 16'd102);
        wr(acc_pkg::IDX_GAIN_TRIM, 16'h0400);
        wr(acc_pkg::IDX_OFFSET_TRIM, 16'h0004);
        conv(12'd100, 1'b1, 16'd48);
        wr(acc_pkg::IDX_GAIN_TRIM, 16'h0FFF);
        wr(acc_pkg::IDX_OFFSET_TRIM, 16'h0000);
        conv(12'd4000, 1'b1, 16'h0FFF);
        wr(acc_pkg::IDX_OFFSET_TRIM, 16'h0005);
        conv(12'd1, 1'b1, 16'h0000);
        wr(acc_pkg::IDX_CORR_CTRL, 16'h0000);
        conv(12'd100, 1'b1, 16'd100);
    endtask

    task automatic t_irq;
        wr(acc_pkg::IDX_WIN_UPPER, 16'd50);
        wr(acc_pkg::IDX_IRQ_STATUS, 16'h0003);
        wr(acc_pkg::IDX_IRQ_MASK, 16'h0002);
        window_enable <= 1'b1;
        conv(12'd40, 1'b1, 16'd40);
        @(posedge ref_clk);
        chk({31'h0, window_hit_flag}, 32'h0);
        conv(12'd100, 1'b1, 16'd100);
        @(posedge ref_clk);
        chk({30'h0, irq, window_hit_flag}, 32'h3);
        rd(acc_pkg::IDX_IRQ_STATUS, 32'h3);
        wr(acc_pkg::IDX_IRQ_STATUS, 16'h0002);
        @(posedge ref_clk);
        chk({30'h0, irq, window_hit_flag}, 32'h0);
        rd(acc_pkg::IDX_IRQ_STATUS, 32'h1);
        wr(acc_pkg::IDX_IRQ_MASK, 16'h0001);
        @(posedge ref_clk);
        chk({31'h0, irq}, 32'h1);
        wr(acc_pkg::IDX_IRQ_MASK, 16'h0000);
        conv(12'd100, 1'b1, 16'd100);
        @(posedge ref_clk);
        chk({30'h0, irq, window_hit_flag}, 32'h1);
    endtask

    // ------------------------------------------------------------
    // clock, timeout and main sequence
    // ------------------------------------------------------------
    initial
    begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    always @(posedge ref_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            errors++;
            end_of_test();
        end
    end

    initial
    begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        pstrb = 4'hF;
        sample_in = '0;
        {conv_enabled, debug_mode, window_enable} = 3'b000;
        reset = 1'b1;
        repeat (16) @(posedge ref_clk);
        reset <= 1'b0;
        @(posedge ref_clk);
        t_regs();
        t_debug();
        t_corr();
        t_irq();
        end_of_test();
    end
endmodule

`default_nettype wire
